// ==== verilog/acd_decoder.sv ====
// Functional notes
// - A command entry is 64 bytes and every field is taken at a fixed byte position.
// - Bytes 40 to 63 are the six command-specific words ten to fifteen, passed on untouched.
// - With selector bit 15 clear, bytes 39:32 are the second page entry and 31:24 the first.
// - With selector bit 15 set, bytes 39:24 are one 16-byte first gather segment descriptor.
// - In page mode the second page entry is a page-list pointer when the transfer spans more than two pages.
// - In page mode the first page entry is a data page or a list pointer as the command defines.
// - A data-block first descriptor describes the whole transfer and no more segments are fetched.
module acd_decoder
	import acd_pkg::*;
(
	input  wire logic                  clk_sys,     // 20 MHz controller clock
	input  wire logic                  rstn,        // Async reset, active low
	input  wire logic                  entry_valid, // Entry present, one pulse
	input  wire logic [ENTRY_BITS-1:0] entry,       // Byte 0 in bits 7:0
	input  wire logic                  spans_multi, // Transfer spans >2 pages
	input  wire logic                  first_list,  // Command treats first as list
	output acd_result_s                result,      // Decoded fields
	output logic                       page_two_list,  // Second entry is a list
	output logic                       page_one_list,  // First entry is a list
	output logic                       result_valid // Result ready, one pulse
);

	logic [NUM_SPECIFIC*DWORD_BITS-1:0] spec_words;
	logic [DWORD_BITS-1:0]              common_word;
	logic                               gather_sel;
	logic [SGD_TYPE_W-1:0]              sgd_type;
	acd_result_s                        result_nxt;
	acd_result_s                        result_r;
	logic                               valid_r;
	logic                               two_list_r;
	logic                               one_list_r;

	// Separate views of bytes 39:24, one per selector setting
	acd_page_s                          page_view;
	logic [SGD_BITS-1:0]                gather_seg;

	// Descriptor type classes of the first gather segment
	logic                               type_is_block;
	logic                               type_is_chain;
	logic                               type_is_bad;

	// Geometry checks: every fixed slice below relies on these relations.
	// A package edit that breaks one of them would silently shift fields,
	// so elaboration stops instead.

	// Six specific words must fill the entry up to its last byte
	if (OFS_WORD_TEN + NUM_SPECIFIC * 4 != ENTRY_BYTES) begin : g_bad_spec
		$error("acd_decoder: specific words do not end the entry");
	end

	// Second page entry must sit directly below word ten
	if (OFS_PAGE_TWO + QWORD_BITS / 8 != OFS_WORD_TEN) begin : g_bad_two
		$error("acd_decoder: second page entry misplaced");
	end

	// First page entry must sit directly below the second
	if (OFS_PAGE_ONE + QWORD_BITS / 8 != OFS_PAGE_TWO) begin : g_bad_one
		$error("acd_decoder: first page entry misplaced");
	end

	// Gather segment must cover exactly the two page entries
	if (OFS_GATHER * 8 + SGD_BITS != OFS_WORD_TEN * 8) begin : g_bad_sgd
		$error("acd_decoder: gather segment misplaced");
	end

	// Both views of the pointer field must be the same size
	if ($bits(acd_page_s) != SGD_BITS) begin : g_bad_view
		$error("acd_decoder: page view and segment differ in size");
	end

	// Selector must lie inside the common word
	if (SEL_BIT >= DWORD_BITS) begin : g_bad_sel
		$error("acd_decoder: selector outside common word");
	end

	// Type field must lie inside the segment
	if (SGD_TYPE_LSB + SGD_TYPE_W > SGD_BITS) begin : g_bad_type
		$error("acd_decoder: type field outside segment");
	end

	// Data-block type code must match the width of the type field
	if ($bits(SGD_DATA_BLOCK) != SGD_TYPE_W) begin : g_bad_code
		$error("acd_decoder: type code width mismatch");
	end

	// Page view: second entry in the upper half, first in the lower
	assign page_view.second_page_entry =
		entry[OFS_PAGE_TWO*8 +: QWORD_BITS];
	assign page_view.first_page_entry =
		entry[OFS_PAGE_ONE*8 +: QWORD_BITS];

	// Gather view: the same sixteen bytes as one descriptor
	assign gather_seg = entry[OFS_GATHER*8 +: SGD_BITS];

	// Type classifier; an unknown code is refused, never guessed
	always_comb begin
		type_is_block = 1'b0;
		type_is_chain = 1'b0;
		type_is_bad   = 1'b0;
		case (sgd_type)
			SGD_DATA_BLOCK: begin
				type_is_block = 1'b1;
			end
			SGD_SEGMENT, SGD_LAST_SEGMENT: begin
				type_is_chain = 1'b1;
			end
			default: begin
				type_is_bad = 1'b1;
			end
		endcase
	end

	// Specific words picked at fixed offsets, ten in the lowest slot
	for (genvar i = 0; i < NUM_SPECIFIC; i++) begin : g_spec
		acd_dword_pick #(
			.BYTE_OFS(OFS_WORD_TEN + 4*i)
		) u_pick (
			.entry(entry),
			.word (spec_words[i*DWORD_BITS +: DWORD_BITS])
		);
	end

	// Common word and its selector
	assign common_word = entry[OFS_COMMON*8 +: DWORD_BITS];
	assign gather_sel  = common_word[SEL_BIT];
	assign sgd_type    = entry[OFS_GATHER*8 + SGD_TYPE_LSB +: SGD_TYPE_W];

	// Field interpretation for the incoming entry
	always_comb begin
		result_nxt = '0;
		result_nxt.specific_words      = spec_words;
		result_nxt.common_command_word = common_word;
		result_nxt.status              = STS_SUCCESS;
		if (!gather_sel) begin
			// Unused view stays zero so handlers never see stale bytes
			result_nxt.mode  = ACD_MODE_PAGE;
			result_nxt.pages = page_view;
		end else begin
			result_nxt.mode                 = ACD_MODE_GATHER;
			result_nxt.first_gather_segment = gather_seg;
			result_nxt.single_descriptor    = type_is_block;
			result_nxt.more_segments        = type_is_chain;
			result_nxt.invalid_field        = type_is_bad;
			if (type_is_bad) begin
				result_nxt.status = STS_INVALID_FIELD;
			end
		end
	end

	// Result capture
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			result_r <= '0;
		end else if (entry_valid) begin
			result_r <= result_nxt;
		end
	end

	// Second entry meaning, only in page mode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			two_list_r <= 1'b0;
		end else if (entry_valid) begin
			two_list_r <= !gather_sel && spans_multi;
		end
	end

	// First entry meaning, only in page mode
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			one_list_r <= 1'b0;
		end else if (entry_valid) begin
			one_list_r <= !gather_sel && first_list;
		end
	end

	// Valid strobe one cycle after the entry
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			valid_r <= 1'b0;
		end else begin
			valid_r <= entry_valid;
		end
	end

	assign result        = result_r;
	assign page_two_list = two_list_r;
	assign page_one_list = one_list_r;
	assign result_valid  = valid_r;

endmodule : acd_decoder

// ==== verilog/acd_pkg.sv ====
package acd_pkg;

	// Entry geometry
	localparam int ENTRY_BYTES  = 64;
	localparam int ENTRY_BITS   = ENTRY_BYTES * 8;
	localparam int DWORD_BITS   = 32;
	localparam int QWORD_BITS   = 64;
	localparam int SGD_BITS     = 128;

	// Byte offsets of fields within one entry
	localparam int OFS_COMMON   = 0;
	localparam int OFS_WORD_TEN = 40;
	localparam int OFS_PAGE_ONE = 24;
	localparam int OFS_PAGE_TWO = 32;
	localparam int OFS_GATHER   = 24;
	localparam int NUM_SPECIFIC = 6;

	// Selector bit inside the common command word
	localparam int SEL_BIT      = 15;

	// Descriptor type sits in the top nibble of the last byte
	localparam int SGD_TYPE_LSB = 124;
	localparam int SGD_TYPE_W   = 4;
	localparam logic [3:0] SGD_DATA_BLOCK   = 4'h0;
	localparam logic [3:0] SGD_SEGMENT      = 4'h2;
	localparam logic [3:0] SGD_LAST_SEGMENT = 4'h3;

	// Status codes for success and for a bad field
	localparam logic [7:0] STS_SUCCESS       = 8'h00;
	localparam logic [7:0] STS_INVALID_FIELD = 8'h02;

	typedef enum logic {
		ACD_MODE_PAGE,
		ACD_MODE_GATHER
	} acd_mode_e;

	// Page-entry view
	typedef struct packed {
		logic [QWORD_BITS-1:0] second_page_entry;
		logic [QWORD_BITS-1:0] first_page_entry;
	} acd_page_s;

	// Decoded result handed on to command handlers
	typedef struct packed {
		logic [NUM_SPECIFIC*DWORD_BITS-1:0] specific_words;
		logic [DWORD_BITS-1:0]              common_command_word;
		acd_mode_e                          mode;
		acd_page_s                          pages;
		logic [SGD_BITS-1:0]                first_gather_segment;
		logic                               single_descriptor;
		logic                               more_segments;
		logic                               invalid_field;
		logic [7:0]                         status;
	} acd_result_s;

endpackage : acd_pkg

// ==== verilog/acd_dword_pick.sv ====
// Extracts one dword at a fixed byte offset from a command entry
module acd_dword_pick
	import acd_pkg::*;
#(
	parameter int BYTE_OFS = 0
) (
	input  wire logic [ENTRY_BITS-1:0] entry, // Whole command entry
	output logic      [DWORD_BITS-1:0] word   // Picked dword
);

	// Offset must be dword aligned and inside the entry
	if (BYTE_OFS % 4 != 0 || BYTE_OFS + 4 > ENTRY_BYTES) begin : g_bad_ofs
		$error("acd_dword_pick: bad offset");
	end

	// Fixed byte slice
	assign word = entry[BYTE_OFS*8 +: DWORD_BITS];

endmodule : acd_dword_pick

// ==== tb/acd_decoder_monitor.sv ====
// Checks decoder outputs against the entry taken one cycle before
module acd_decoder_monitor
	import acd_pkg::*;
(
	input wire logic                  clk_sys,       // Clock
	input wire logic                  rstn,          // Reset, active low
	input wire logic                  entry_valid,   // Entry strobe
	input wire logic [ENTRY_BITS-1:0] entry,         // Command entry
	input wire logic                  spans_multi,   // Multi-page span
	input wire logic                  first_list,    // First is a list
	input acd_result_s                result,        // Decoded fields
	input wire logic                  page_two_list, // Second is a list
	input wire logic                  page_one_list, // First is a list
	input wire logic                  result_valid   // Result pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	a_answer_one_cycle: assert property (entry_valid |=> result_valid)
		else $error("result_valid missing");
	a_no_spurious_answer: assert property (!entry_valid |=> !result_valid)
		else $error("result_valid without entry");
	a_specific_words: assert property (entry_valid |=>
		result.specific_words == $past(entry[511:320]))
		else $error("specific words wrong");
	a_page_fields: assert property (entry_valid && !entry[SEL_BIT] |=>
		result.pages == $past(entry[319:192]))
		else $error("page entries wrong");
	a_gather_field: assert property (entry_valid && entry[SEL_BIT] |=>
		result.first_gather_segment == $past(entry[319:192]))
		else $error("gather segment wrong");
	a_second_list: assert property (entry_valid |=>
		page_two_list == $past(!entry[SEL_BIT] && spans_multi))
		else $error("second list flag wrong");
	a_first_list: assert property (entry_valid |=>
		page_one_list == $past(!entry[SEL_BIT] && first_list))
		else $error("first list flag wrong");
	a_single_block: assert property (entry_valid && entry[SEL_BIT]
		&& entry[319:316] == 4'h0 |=> result.single_descriptor)
		else $error("data block not single");
	a_bad_type: assert property (entry_valid && entry[SEL_BIT]
		&& entry[319:316] == 4'h5 |=> result.status == STS_INVALID_FIELD)
		else $error("bad type not refused");
	c_page: cover property (entry_valid && !entry[SEL_BIT]);
	c_gather: cover property (entry_valid && entry[SEL_BIT]);
	c_b2b: cover property (entry_valid [*2]);
endmodule : acd_decoder_monitor

bind acd_decoder acd_decoder_monitor u_mon (.*);

// ==== tb/acd_host_model.sv ====
// Host side: lays out one command entry from a few chosen fields
module acd_host_model
	import acd_pkg::*;
(
	input wire logic            gather, // Gather mode selector
	input wire logic [3:0]      dtype,  // First descriptor type
	input wire logic [7:0]      seed,   // Byte pattern start
	output logic [ENTRY_BITS-1:0] entry // Built entry
);
	timeunit 1ns;
	timeprecision 1ns;
	// Every byte at its fixed place, then selector and type
	always_comb begin
		for (int i = 0; i < ENTRY_BYTES; i++) entry[8*i +: 8] = seed + 8'(i);
		entry[SEL_BIT] = gather;
		if (gather) entry[319:316] = dtype;
	end
endmodule : acd_host_model

// ==== tb/testbench.sv ====
// Self-checking bench for the command field decoder
module testbench
	import acd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 0, rstn = 0, entry_valid = 0, spans_multi = 0;
	logic first_list = 0, gather = 0, page_two_list, page_one_list, result_valid;
	logic [3:0] dtype = 0;
	logic [7:0] seed = 0;
	logic [ENTRY_BITS-1:0] entry;
	acd_result_s result;
	int bad_count = 0, samples_checked = 0;
	acd_host_model u_host (.gather(gather), .dtype(dtype), .seed(seed), .entry(entry));
	acd_decoder u_dut (.clk_sys(clk_sys), .rstn(rstn), .entry_valid(entry_valid),
		.entry(entry), .spans_multi(spans_multi), .first_list(first_list),
		.result(result), .page_two_list(page_two_list),
		.page_one_list(page_one_list), .result_valid(result_valid));
	always #25 clk_sys = ~clk_sys;
	task chk(string name, logic [255:0] seen, logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %0h seen %0h", name, exp, seen);
		end
	endtask : chk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : tally_and_finish
	// One entry in, result judged the cycle after
	task send(logic g, logic [3:0] t, logic [7:0] s, logic sp, logic fl);
		@(negedge clk_sys);
		{gather, dtype, seed, spans_multi, first_list} = {g, t, s, sp, fl};
		entry_valid = 1;
		@(negedge clk_sys);
		entry_valid = 0;
		chk("valid", result_valid, 1);
		chk("words", result.specific_words, entry[511:320]);
		chk("pages", result.pages, g ? 0 : entry[319:192]);
		chk("segment", result.first_gather_segment, g ? entry[319:192] : 0);
		chk("second_list", page_two_list, !g && sp);
		chk("first_list", page_one_list, !g && fl);
		chk("single", result.single_descriptor, g && t == 0);
		chk("more", result.more_segments, g && (t == 2 || t == 3));
		chk("status", result.status, (g && !(t inside {0, 2, 3})) ?
			STS_INVALID_FIELD : STS_SUCCESS);
		chk("invalid", result.invalid_field, g && !(t inside {0, 2, 3}));
		chk("mode", result.mode, g);
		chk("common", result.common_command_word, entry[31:0]);
	endtask : send
	// Page mode with every list-flag pairing
	task t_page;
		for (int i = 0; i < 4; i++) send(0, 4'h3, 8'(16 * i), i[0], i[1]);
		$display("test page done");
	endtask : t_page
	// Gather mode with valid and invalid descriptor types
	task t_gather;
		for (int i = 0; i < 6; i++) send(1, 4'(i), 8'hA0 + 8'(i), 1, 1);
		$display("test gather done");
	endtask : t_gather
	// Two entries one idle cycle apart, then a quiet cycle
	task t_b2b;
		send(1, 4'h0, 8'h11, 0, 0);
		send(0, 4'h0, 8'h22, 1, 0);
		@(negedge clk_sys);
		chk("idle", result_valid, 0);
		chk("hold", result.pages, entry[319:192]);
		$display("test b2b done");
	endtask : t_b2b
	// Entries on consecutive cycles, each result judged as it stands
	task t_stream;
		logic [ENTRY_BITS-1:0] first_e;
		@(negedge clk_sys);
		{gather, seed} = {1'b0, 8'h40};
		entry_valid = 1;
		@(negedge clk_sys);
		first_e = entry;
		{gather, seed} = {1'b1, 8'h50};
		chk("stream_valid", result_valid, 1);
		chk("stream_pages", result.pages, first_e[319:192]);
		@(negedge clk_sys);
		entry_valid = 0;
		chk("stream_valid2", result_valid, 1);
		chk("stream_seg", result.first_gather_segment, entry[319:192]);
		$display("test stream done");
	endtask : t_stream
	// Reset in mid-run clears valid, pages and second list flag, then decoding resumes
	task t_reset;
		@(negedge clk_sys);
		{gather, seed, spans_multi} = {1'b0, 8'h60, 1'b1};
		entry_valid = 1;
		@(negedge clk_sys);
		entry_valid = 0;
		rstn = 0;
		@(negedge clk_sys);
		chk("rst_valid", result_valid, 0);
		chk("rst_pages", result.pages, 0);
		chk("rst_list", page_two_list, 0);
		rstn = 1;
		@(negedge clk_sys);
		chk("rst_idle", result_valid, 0);
		send(1, 4'h2, 8'h70, 0, 0);
		$display("test reset done");
	endtask : t_reset
	initial begin
		repeat (5) @(posedge clk_sys);
		@(negedge clk_sys);
		rstn = 1;
		t_page();
		t_gather();
		t_b2b();
		t_stream();
		t_reset();
		tally_and_finish();
	end
	// Watchdog against a hung run
	initial begin
		#100us;
		bad_count++;
		tally_and_finish();
	end
endmodule : testbench
